/* rple_top.sv */
// Latched event status bits, masks and interrupt outputs of the receiver
// Operation
// - Vendor infoframe change sets status A bit 4
// - MPEG infoframe change sets status A bit 3
// - Product descriptor change sets status A bit 2
// - Audio infoframe change sets status A bit 1
// - Channel status valid change sets B bit 7
// - Inner mute change sets B bit 6
// - Audio video mute change sets B bit 5
// - Audio channel mode change sets B bit 4
// - Protocol mode change sets B bit 3
// - General control packet change sets B bit 2
// - Clock regeneration packet change sets B bit 1
// - Gamut metadata change sets B bit 0
// - PLL lock change sets C bit 6
// - Set bits hold until their clear is written
// - Status bits read-only, zero after reset
// - Bit latches only when a mask or the store control enables it
// - Store control latches regardless of masks, no pin
`timescale 1ns/10ps
`default_nettype none
`include "rple_consts.svh"

module rple_top
  import rple_pkg::*;
(
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [9:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // Raw conditions from the detectors
  input wire rple_raw_s I_RAW,
  // Interrupt outputs, active high levels
  output logic O_FIRST_IRQ_OUTPUT,
  output logic O_SECOND_IRQ_OUTPUT
);

  // ************************************************************
  // Constants and declarations
  // ************************************************************
  localparam rple_state_s ST_RST = '{
    stat_a: `RPLE_RST_STAT, stat_b: `RPLE_RST_STAT, stat_c: `RPLE_RST_STAT,
    m1_a: `RPLE_RST_MASK, m1_b: `RPLE_RST_MASK, m1_c: `RPLE_RST_MASK,
    m2_a: `RPLE_RST_MASK, m2_b: `RPLE_RST_MASK, m2_c: `RPLE_RST_MASK,
    store: `RPLE_RST_STORE, ack: 1'b0, dat: 32'h0000_0000};

  rple_state_s st_ff; // All state
  rple_state_s nxt_st; // Next state
  rple_raw_s evt; // One-cycle change pulses
  logic [7:0] ev_a; // Events in status A layout
  logic [7:0] ev_b; // Events in status B layout
  logic [7:0] ev_c; // Events in status C layout
  logic req; // Live bus request
  logic wr; // Write taking effect this edge
  logic [7:0] wd; // Low write byte
  logic [31:0] rd; // Read data for the current address

  // ************************************************************
  // Functions
  // ************************************************************
  // Address hit on a register index; low two address bits ignored
  function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
    hit = (adr[9:2] == idx);
  endfunction

  // Next value of one status register
  function automatic logic [7:0] upd(
    input logic [7:0] cur,
    input logic [7:0] ev,
    input logic [7:0] en,
    input logic [7:0] clr,
    input logic [7:0] impl
  );
    logic [7:0] set;
    set = ev & en & impl;
    // A set in the same cycle as a clear wins, so no event is lost
    upd = (cur & ~clr) | set;
  endfunction

  // ************************************************************
  // Change detection
  // ************************************************************
  // Raw signals come from other clock domains and are synchronised here
  rple_sync_edge u_sync (
    .i_clk(I_CORE_CLK),
    .i_rstn(I_RSTN),
    .i_raw(I_RAW),
    .o_evt(evt)
  );

  // Place each event at its status bit
  always_comb
  begin
    ev_a = 8'h00;
    ev_b = 8'h00;
    ev_c = 8'h00;
    ev_a[`RPLE_BIT_VENDOR] = evt.vendor_infoframe_raw;
    ev_a[`RPLE_BIT_MPEG] = evt.mpeg_infoframe_raw;
    ev_a[`RPLE_BIT_PRODUCT] = evt.product_descriptor_raw;
    ev_a[`RPLE_BIT_AUDIO_IF] = evt.audio_infoframe_raw;
    ev_b[7] = evt.chan_status_valid_raw;
    ev_b[6] = evt.inner_mute_raw;
    ev_b[5] = evt.audio_video_mute_raw;
    ev_b[4] = evt.audio_channel_mode_raw;
    ev_b[3] = evt.link_protocol_mode_raw;
    ev_b[2] = evt.general_control_packet_raw;
    ev_b[1] = evt.clock_regen_packet_raw;
    ev_b[0] = evt.gamut_metadata_raw;
    ev_c[`RPLE_BIT_PLL_LOCK] = evt.port_a_pll_lock_raw;
  end

  // ************************************************************
  // Bus decode and read mux
  // ************************************************************
  assign req = I_WB_CYC & I_WB_STB;
  // Writes land at the edge where the master sees ack; only lane 0 carries data
  assign wr = req & I_WB_WE & st_ff.ack & I_WB_SEL[0];
  assign wd = I_WB_DAT[7:0];

  // Read value; clear registers and unmapped words read zero
  always_comb
  begin
    rd = 32'h0000_0000;
    if (hit(I_WB_ADR, `RPLE_IDX_STAT_A))
    begin
      rd[7:0] = st_ff.stat_a;
    end
    else if (hit(I_WB_ADR, `RPLE_IDX_STAT_B))
    begin
      rd[7:0] = st_ff.stat_b;
    end
    else if (hit(I_WB_ADR, `RPLE_IDX_STAT_C))
    begin
      rd[7:0] = st_ff.stat_c;
    end
    else if (hit(I_WB_ADR, `RPLE_IDX_M1_A))
    begin
      rd[7:0] = st_ff.m1_a;
    end
    else if (hit(I_WB_ADR, `RPLE_IDX_M1_B))
    begin
      rd[7:0] = st_ff.m1_b;
    end
    else if (hit(I_WB_ADR, `RPLE_IDX_M1_C))
    begin
      rd[7:0] = st_ff.m1_c;
    end
    else if (hit(I_WB_ADR, `RPLE_IDX_M2_A))
    begin
      rd[7:0] = st_ff.m2_a;
    end
    else if (hit(I_WB_ADR, `RPLE_IDX_M2_B))
    begin
      rd[7:0] = st_ff.m2_b;
    end
    else if (hit(I_WB_ADR, `RPLE_IDX_M2_C))
    begin
      rd[7:0] = st_ff.m2_c;
    end
    else if (hit(I_WB_ADR, `RPLE_IDX_CTRL))
    begin
      rd[`RPLE_BIT_STORE] = st_ff.store;
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    nxt_st = st_ff;
    // Ack one cycle after the request, dropped the cycle after
    nxt_st.ack = req & ~st_ff.ack;
    // Read data is captured with the ack so it comes from a flip-flop
    if (req & ~st_ff.ack)
    begin
      nxt_st.dat = rd;
    end
    // Status words: masks or the store control gate each set
    nxt_st.stat_a = upd(st_ff.stat_a, ev_a,
      st_ff.m1_a | st_ff.m2_a | {8{st_ff.store}},
      (wr & hit(I_WB_ADR, `RPLE_IDX_CLR_A)) ? wd : 8'h00, `RPLE_IMPL_A);
    nxt_st.stat_b = upd(st_ff.stat_b, ev_b,
      st_ff.m1_b | st_ff.m2_b | {8{st_ff.store}},
      (wr & hit(I_WB_ADR, `RPLE_IDX_CLR_B)) ? wd : 8'h00, `RPLE_IMPL_B);
    nxt_st.stat_c = upd(st_ff.stat_c, ev_c,
      st_ff.m1_c | st_ff.m2_c | {8{st_ff.store}},
      (wr & hit(I_WB_ADR, `RPLE_IDX_CLR_C)) ? wd : 8'h00, `RPLE_IMPL_C);
    // Writable registers; status words ignore writes
    if (wr)
    begin
      if (hit(I_WB_ADR, `RPLE_IDX_M1_A))
      begin
        nxt_st.m1_a = wd & `RPLE_IMPL_A;
      end
      else if (hit(I_WB_ADR, `RPLE_IDX_M1_B))
      begin
        nxt_st.m1_b = wd & `RPLE_IMPL_B;
      end
      else if (hit(I_WB_ADR, `RPLE_IDX_M1_C))
      begin
        nxt_st.m1_c = wd & `RPLE_IMPL_C;
      end
      else if (hit(I_WB_ADR, `RPLE_IDX_M2_A))
      begin
        nxt_st.m2_a = wd & `RPLE_IMPL_A;
      end
      else if (hit(I_WB_ADR, `RPLE_IDX_M2_B))
      begin
        nxt_st.m2_b = wd & `RPLE_IMPL_B;
      end
      else if (hit(I_WB_ADR, `RPLE_IDX_M2_C))
      begin
        nxt_st.m2_c = wd & `RPLE_IMPL_C;
      end
      else if (hit(I_WB_ADR, `RPLE_IDX_CTRL))
      begin
        nxt_st.store = wd[`RPLE_BIT_STORE];
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      st_ff <= ST_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign O_WB_ACK = st_ff.ack;
  assign O_WB_DAT = st_ff.dat;
  // Store control alone never raises a pin: only masked status does
  assign O_FIRST_IRQ_OUTPUT = |{st_ff.stat_a & st_ff.m1_a, st_ff.stat_b & st_ff.m1_b,
    st_ff.stat_c & st_ff.m1_c};
  assign O_SECOND_IRQ_OUTPUT = |{st_ff.stat_a & st_ff.m2_a, st_ff.stat_b & st_ff.m2_b,
    st_ff.stat_c & st_ff.m2_c};

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RSTN);

  logic clr_a4; // Clear of status A bit 4 takes effect
  assign clr_a4 = wr & hit(I_WB_ADR, `RPLE_IDX_CLR_A) & wd[`RPLE_BIT_VENDOR];

  // Enabled status per pin, rebuilt from the masks so the pins are checked
  // against the rule; the store control alone must never count here
  logic [7:0] live1; // Status bits enabled for the first pin
  logic [7:0] live2; // Status bits enabled for the second pin
  assign live1 = (st_ff.stat_a & st_ff.m1_a) | (st_ff.stat_b & st_ff.m1_b)
    | (st_ff.stat_c & st_ff.m1_c);
  assign live2 = (st_ff.stat_a & st_ff.m2_a) | (st_ff.stat_b & st_ff.m2_b)
    | (st_ff.stat_c & st_ff.m2_c);

  AST_VENDOR_SET: assert property (
    evt.vendor_infoframe_raw && (st_ff.m1_a[4] || st_ff.m2_a[4] || st_ff.store)
    |=> st_ff.stat_a[4])
    else $error("Vendor event not latched");

  AST_MPEG_CAUSE: assert property (
    $rose(st_ff.stat_a[3]) |-> $past(evt.mpeg_infoframe_raw)
    && ($past(st_ff.m1_a[3]) || $past(st_ff.m2_a[3]) || $past(st_ff.store)))
    else $error("MPEG status rose without enabled event");

  AST_GAMUT_STORE: assert property (
    evt.gamut_metadata_raw && st_ff.store |=> st_ff.stat_b[0])
    else $error("Store control failed to latch gamut event");

  AST_PLL_SET: assert property (
    evt.port_a_pll_lock_raw && st_ff.m2_c[6] |=> st_ff.stat_c[6] && O_SECOND_IRQ_OUTPUT)
    else $error("PLL lock event not latched or no irq");

  AST_HOLD: assert property (
    st_ff.stat_a[4] && !clr_a4 |=> st_ff.stat_a[4])
    else $error("Status bit dropped without clear");

  // Collision of clear and event: the event must survive the clear
  AST_SET_WINS: assert property (
    clr_a4 && evt.vendor_infoframe_raw && st_ff.m1_a[4] |=> st_ff.stat_a[4])
    else $error("Clear beat a same-cycle event");

  AST_RESERVED_ZERO: assert property (
    (st_ff.stat_a & ~`RPLE_IMPL_A) == 8'h00 && (st_ff.stat_c & ~`RPLE_IMPL_C) == 8'h00)
    else $error("Unimplemented status bit set");

  AST_IRQ1: assert property (
    live1 != 8'h00 |-> O_FIRST_IRQ_OUTPUT)
    else $error("First irq low with masked status set");

  AST_IRQ2: assert property (
    live2 != 8'h00 |-> O_SECOND_IRQ_OUTPUT)
    else $error("Second irq low with masked status set");

  AST_PIN_NEEDS_MASK: assert property (
    O_FIRST_IRQ_OUTPUT || O_SECOND_IRQ_OUTPUT |-> (live1 | live2) != 8'h00)
    else $error("Irq pin high with no masked status");

  AST_CLEAR: assert property (
    clr_a4 && !evt.vendor_infoframe_raw |=> !st_ff.stat_a[4])
    else $error("Clear write left status set");

  AST_NO_EN_NO_SET: assert property (
    !st_ff.stat_b[5] && !st_ff.m1_b[5] && !st_ff.m2_b[5] && !st_ff.store
    |=> !st_ff.stat_b[5])
    else $error("Disabled status bit got set");

  // Ack comes one cycle late and drops at once, so a held request is not taken twice
  AST_ACK_ONCE: assert property (
    req && !st_ff.ack |=> O_WB_ACK ##1 !O_WB_ACK)
    else $error("Ack not a single pulse one cycle after request");

  // Main scenarios the bench is expected to reach
  COV_SET_CLEAR: cover property (st_ff.stat_a[4] ##[1:50] !st_ff.stat_a[4]);
  COV_STORE_NO_IRQ: cover property (st_ff.store && st_ff.stat_b[0] && !O_FIRST_IRQ_OUTPUT);
  COV_COLLIDE: cover property (clr_a4 && evt.vendor_infoframe_raw && st_ff.m1_a[4]);
  COV_BOTH_IRQ: cover property (O_FIRST_IRQ_OUTPUT && O_SECOND_IRQ_OUTPUT);
  COV_PLL_IRQ2: cover property (st_ff.stat_c[6] && O_SECOND_IRQ_OUTPUT);

endmodule
`default_nettype wire

/* rple_consts.svh */
// Offsets, field positions, reset values and timing counts of the event latches
`ifndef RPLE_CONSTS_SVH
`define RPLE_CONSTS_SVH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define RPLE_IDX_CTRL 8'h40
`define RPLE_IDX_STAT_A 8'h61
`define RPLE_IDX_CLR_A 8'h62
`define RPLE_IDX_M1_A 8'h63
`define RPLE_IDX_M2_A 8'h64
`define RPLE_IDX_STAT_B 8'h66
`define RPLE_IDX_CLR_B 8'h67
`define RPLE_IDX_M1_B 8'h68
`define RPLE_IDX_M2_B 8'h69
`define RPLE_IDX_STAT_C 8'h6B
`define RPLE_IDX_CLR_C 8'h6C
`define RPLE_IDX_M1_C 8'h6D
`define RPLE_IDX_M2_C 8'h6E

// ************************************************************
// Field positions
// ************************************************************
`define RPLE_BIT_STORE 4
`define RPLE_BIT_VENDOR 4
`define RPLE_BIT_MPEG 3
`define RPLE_BIT_PRODUCT 2
`define RPLE_BIT_AUDIO_IF 1
`define RPLE_BIT_PLL_LOCK 6

// ************************************************************
// Implemented bits and reset values
// ************************************************************
`define RPLE_IMPL_A 8'h1E
`define RPLE_IMPL_B 8'hFF
`define RPLE_IMPL_C 8'h40
`define RPLE_RST_STAT 8'h00
`define RPLE_RST_MASK 8'h00
`define RPLE_RST_STORE 1'b0

// ************************************************************
// Timing counts
// ************************************************************
`define RPLE_SYNC_PRIME 2'h3

`endif

/* rple_pkg.sv */
// Types shared by the event latch block
package rple_pkg;

  // ************************************************************
  // Raw conditions, one bit each, in status order
  // ************************************************************
  typedef struct packed {
    logic vendor_infoframe_raw;
    logic mpeg_infoframe_raw;
    logic product_descriptor_raw;
    logic audio_infoframe_raw;
    logic chan_status_valid_raw;
    logic inner_mute_raw;
    logic audio_video_mute_raw;
    logic audio_channel_mode_raw;
    logic link_protocol_mode_raw;
    logic general_control_packet_raw;
    logic clock_regen_packet_raw;
    logic gamut_metadata_raw;
    logic port_a_pll_lock_raw;
  } rple_raw_s;

  // ************************************************************
  // Whole state of the top module
  // ************************************************************
  typedef struct packed {
    logic [7:0] stat_a;
    logic [7:0] stat_b;
    logic [7:0] stat_c;
    logic [7:0] m1_a;
    logic [7:0] m1_b;
    logic [7:0] m1_c;
    logic [7:0] m2_a;
    logic [7:0] m2_b;
    logic [7:0] m2_c;
    logic store;
    logic ack;
    logic [31:0] dat;
  } rple_state_s;

  // State of the synchroniser and edge finder
  typedef struct packed {
    logic [12:0] s1;
    logic [12:0] s2;
    logic [12:0] s3;
    logic [1:0] prime;
  } rple_sync_s;

endpackage

/* rple_sync_edge.sv */
// Two-stage synchroniser and change finder for the raw conditions
`timescale 1ns/10ps
`default_nettype none
`include "rple_consts.svh"

module rple_sync_edge
  import rple_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Raw conditions from other domains
  input wire logic [12:0] i_raw,
  // One-cycle change pulses
  output logic [12:0] o_evt
);

  rple_sync_s st_ff; // All state
  rple_sync_s nxt_st; // Next state

  // ************************************************************
  // Next state
  // ************************************************************
  // First stage feeds only the second; the edge finder looks at stages two and three
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = i_raw;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // Hold off until stage three carries real history
    if (st_ff.prime != `RPLE_SYNC_PRIME)
    begin
      nxt_st.prime = st_ff.prime + 2'h1;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Either direction counts as a change; a level at reset is not one
  assign o_evt = (st_ff.prime == `RPLE_SYNC_PRIME) ? (st_ff.s2 ^ st_ff.s3) : 13'h0000;

endmodule
`default_nettype wire

/* rple_top_tb_top.sv */
// Self-checking bench for the latched event status block
`timescale 1ns/10ps
`default_nettype none
`include "rple_consts.svh"

// Compare a seen value with an expected one and count the result
`define CHK(nm, ex, gt) \
  begin \
    checked++; \
    if ((gt) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module rple_top_tb_top;
  import rple_pkg::*;

  // ************************************************************
  // Signals and counters
  // ************************************************************
  logic clk = 1'b0; // 10 MHz core clock
  logic rstn = 1'b0; // Active low reset
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat; // Read data from the block
  logic ack; // Bus answer
  rple_raw_s raw = '0; // Raw condition levels
  logic irq1; // First interrupt output
  logic irq2; // Second interrupt output
  int n_mismatch = 0;
  int checked = 0;
  logic [10:0] l; // Status index and bit of one condition
  logic [7:0] ex; // Expected status byte
  logic [31:0] dq; // Read data of a write, not used

  // Clock with a 100 ns period
  always #50 clk = ~clk;

  // ************************************************************
  // Device under test
  // ************************************************************
  rple_top uut (
    .I_CORE_CLK(clk),
    .I_RSTN(rstn),
    .I_WB_CYC(cyc),
    .I_WB_STB(stb),
    .I_WB_WE(we),
    .I_WB_ADR(adr),
    .I_WB_SEL(sel),
    .I_WB_DAT(wdat),
    .O_WB_DAT(rdat),
    .O_WB_ACK(ack),
    .I_RAW(raw),
    .O_FIRST_IRQ_OUTPUT(irq1),
    .O_SECOND_IRQ_OUTPUT(irq2)
  );

  // ************************************************************
  // Tasks
  // ************************************************************
  // Print the counts and the verdict, then stop
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One classic Wishbone cycle; the request holds until ack is sampled
  task automatic wb(input logic w, input logic [7:0] idx, input logic [3:0] s,
                    input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    sel <= s;
    wdat <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20)
    begin
      // A bus that never answers ends the run
      n_mismatch++;
      conclude();
    end
  endtask

  // Write one byte in lane 0
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, 4'h1, d, q);
  endtask

  // Read one register and compare it with the expected byte
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, idx, 4'hF, 8'h00, q);
    `CHK($sformatf("reg %h", idx), {24'h000000, e}, q)
  endtask

  // Compare both interrupt outputs
  task automatic ichk(input logic e1, input logic e2);
    `CHK("first irq", e1, irq1)
    `CHK("second irq", e2, irq2)
  endtask

  // Wait a number of clock edges
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Flip raw conditions given as a bit vector
  task automatic flip(input logic [12:0] m);
    @(posedge clk);
    raw <= rple_raw_s'(raw ^ m);
  endtask

  // Reset for four cycles, then let the change finder come out of blindness
  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    idle(4);
    rstn <= 1'b1;
    idle(4);
  endtask

  // Status register and bit of condition i, counted from the struct lsb
  function automatic logic [10:0] loc(input int i);
    if (i >= 9)
      return {`RPLE_IDX_STAT_A, 3'(i - 8)};
    else if (i >= 1)
      return {`RPLE_IDX_STAT_B, 3'(i - 1)};
    else
      return {`RPLE_IDX_STAT_C, 3'h6};
  endfunction

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    idle(4);
    rstn <= 1'b1;
    idle(4);
    // Everything comes out of reset clear
    rchk(`RPLE_IDX_STAT_A, `RPLE_RST_STAT);
    rchk(`RPLE_IDX_STAT_B, `RPLE_RST_STAT);
    rchk(`RPLE_IDX_STAT_C, `RPLE_RST_STAT);
    rchk(`RPLE_IDX_CTRL, 8'h00);
    rchk(`RPLE_IDX_M1_A, `RPLE_RST_MASK);
    ichk(1'b0, 1'b0);
    // Changes with no mask and no store are dropped
    flip(13'h1FFF);
    idle(6);
    rchk(`RPLE_IDX_STAT_A, 8'h00);
    rchk(`RPLE_IDX_STAT_B, 8'h00);
    rchk(`RPLE_IDX_STAT_C, 8'h00);
    // Group A on the first output, groups B and C on the second
    wr(`RPLE_IDX_M1_A, 8'hFF);
    wr(`RPLE_IDX_M2_B, 8'hFF);
    wr(`RPLE_IDX_M2_C, 8'hFF);
    rchk(`RPLE_IDX_M1_A, `RPLE_IMPL_A);
    rchk(`RPLE_IDX_M2_C, `RPLE_IMPL_C);
    // Each condition alone, first pass one edge, second pass the other
    for (int j = 0; j < 2; j++)
    begin
      for (int i = 12; i >= 0; i--)
      begin
        l = loc(i);
        ex = 8'h01 << l[2:0];
        flip(13'h0001 << i);
        idle(6);
        rchk(l[10:3], ex);
        ichk(l[10:3] == `RPLE_IDX_STAT_A, l[10:3] != `RPLE_IDX_STAT_A);
        wb(1'b1, l[10:3] + 8'h01, 4'h0, ex, dq); // Clear with lane 0 disabled
        idle(8);
        rchk(l[10:3], ex);
        wr(l[10:3] + 8'h01, ~ex); // Clearing the other bits leaves this one
        rchk(l[10:3], ex);
        wr(l[10:3] + 8'h01, ex);
        rchk(l[10:3], 8'h00);
        ichk(1'b0, 1'b0);
      end
    end
    // Store control latches with no mask and keeps the pins quiet
    wr(`RPLE_IDX_M1_A, 8'h00);
    wr(`RPLE_IDX_M2_B, 8'h00);
    wr(`RPLE_IDX_M2_C, 8'h00);
    wr(`RPLE_IDX_CTRL, 8'h10);
    rchk(`RPLE_IDX_CTRL, 8'h10);
    flip(13'h1FFF);
    idle(6);
    rchk(`RPLE_IDX_STAT_A, `RPLE_IMPL_A);
    rchk(`RPLE_IDX_STAT_B, `RPLE_IMPL_B);
    rchk(`RPLE_IDX_STAT_C, `RPLE_IMPL_C);
    ichk(1'b0, 1'b0);
    // Masking an already set bit raises the pin at once
    wr(`RPLE_IDX_M2_A, 8'h02);
    idle(1);
    ichk(1'b0, 1'b1);
    // Status words ignore writes
    wr(`RPLE_IDX_STAT_A, 8'h00);
    rchk(`RPLE_IDX_STAT_A, `RPLE_IMPL_A);
    wr(`RPLE_IDX_CLR_A, 8'hFF);
    wr(`RPLE_IDX_CLR_B, 8'hFF);
    ichk(1'b0, 1'b0);
    wr(`RPLE_IDX_STAT_B, 8'hFF);
    rchk(`RPLE_IDX_STAT_B, 8'h00);
    // Unmapped place answers, reads zero and keeps nothing
    wr(8'h7F, 8'hFF);
    rchk(8'h7F, 8'h00);
    // A change lands on the edge that takes the clear of the same bit
    flip(13'h0001);
    wr(`RPLE_IDX_CLR_C, 8'h40);
    idle(6);
    rchk(`RPLE_IDX_STAT_C, 8'h40);
    wr(`RPLE_IDX_CLR_C, 8'h40);
    rchk(`RPLE_IDX_STAT_C, 8'h00);
    // Same collision on a masked bit; a second bit set alongside drives the other pin
    wr(`RPLE_IDX_M1_A, 8'h10);
    flip(13'h1200);
    wr(`RPLE_IDX_CLR_A, 8'h10);
    idle(6);
    rchk(`RPLE_IDX_STAT_A, 8'h12);
    ichk(1'b1, 1'b1);
    // A second reset in mid-run clears status, masks and store
    flip(13'h1000);
    idle(6);
    do_reset();
    rchk(`RPLE_IDX_STAT_A, `RPLE_RST_STAT);
    rchk(`RPLE_IDX_M2_A, `RPLE_RST_MASK);
    rchk(`RPLE_IDX_CTRL, 8'h00);
    ichk(1'b0, 1'b0);
    conclude();
  end
endmodule

`default_nettype wire
